/* File: rph_pkg.sv */
// Purpose: Shared constants and types for the radio packet handler.
// Assumes: One 100 MHz clock; registers reached over the serial register port.
// Notes: Offsets are register addresses on the serial port, six bits wide.
package rph_pkg;
  // ==========================================================
  // Register map
  localparam logic [5:0] REG_MAX_LEN = 6'h06;
  localparam logic [5:0] REG_PKT_CTRL_ONE = 6'h07;
  localparam logic [5:0] REG_PKT_CTRL_ZERO = 6'h08;
  localparam logic [5:0] REG_NODE_ADDR = 6'h09;
  localparam logic [7:0] RST_MAX_LEN = 8'hFF;
  localparam logic [7:0] RST_PKT_CTRL_ONE = 8'h04;
  localparam logic [7:0] RST_PKT_CTRL_ZERO = 8'h45;
  localparam logic [7:0] RST_NODE_ADDR = 8'h00;
  localparam logic [7:0] MASK_PKT_CTRL_ONE = 8'hEF;
  localparam logic [7:0] MASK_PKT_CTRL_ZERO = 8'h7F;
  // ==========================================================
  // Field positions
  localparam int PQT_LSB = 5;
  localparam int AUTOFLUSH_BIT = 3;
  localparam int APPEND_BIT = 2;
  localparam int ADR_MODE_LSB = 0;
  localparam int WHITE_BIT = 6;
  localparam int FMT_LSB = 4;
  localparam int COMPAT_BIT = 3;
  localparam int CRC_EN_BIT = 2;
  localparam int LEN_MODE_LSB = 0;
  localparam int SPI_RD_BIT = 7;
  localparam int SPI_BURST_BIT = 6;
  // ==========================================================
  // Codes and counts
  localparam logic [4:0] PQ_MAX = 5'h1F;
  localparam logic [4:0] PQ_DOWN = 5'h04;
  localparam logic [4:0] PQ_UP = 5'h01;
  localparam int PQT_SHIFT = 2;
  localparam logic [1:0] ADR_OFF = 2'h0;
  localparam logic [1:0] ADR_NO_BCAST = 2'h1;
  localparam logic [1:0] ADR_BCAST_LOW = 2'h2;
  localparam logic [1:0] ADR_BCAST_BOTH = 2'h3;
  localparam logic [7:0] BCAST_LOW = 8'h00;
  localparam logic [7:0] BCAST_HIGH = 8'hFF;
  localparam logic [1:0] FMT_FIFO = 2'h0;
  localparam logic [1:0] FMT_SERIAL_SYNC = 2'h1;
  localparam logic [1:0] FMT_PN9 = 2'h2;
  localparam logic [1:0] FMT_ASYNC = 2'h3;
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VARIABLE = 2'h1;
  localparam logic [1:0] LEN_INFINITE = 2'h2;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_POLY_LEGACY = 16'h1021;
  localparam logic [8:0] PN9_SEED = 9'h1FF;
  localparam logic [3:0] SPI_HDR_LAST = 4'h7;
  localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
  localparam logic [3:0] SPI_DATA_LAST = 4'hF;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    RX_IDLE, RX_LEN, RX_ADDR, RX_DATA, RX_CRC_HI, RX_CRC_LO, RX_STAT_RSSI, RX_STAT_LQI
  } rph_rx_state_t;
  typedef struct packed {
    logic bit_valid;
    logic bit_val;
    logic sync_hit;
    logic byte_valid;
    logic [7:0] byte_data;
    logic end_frame;
  } rph_rx_in_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic flush;
  } rph_fifo_wr_t;
  typedef struct packed {
    logic [7:0] max_len;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_zero;
    logic [7:0] node_addr;
    logic [2:0] sclk_s;
    logic [1:0] csn_s;
    logic [1:0] si_s;
    logic [1:0] gp0_s;
    logic [3:0] spi_cnt;
    logic [7:0] spi_rx_sh;
    logic [7:0] spi_tx_sh;
    logic [5:0] spi_addr;
    logic spi_rd;
    logic spi_burst;
    logic spi_so;
    logic spi_so_oe;
    logic [4:0] pq;
    logic prev_bit;
    rph_rx_state_t rx_state;
    logic [7:0] rem;
    logic [7:0] len_hold;
    logic [7:0] pend_data;
    logic pend;
    logic [15:0] rx_crc;
    logic [8:0] rx_pn9;
    logic crc_ok;
    rph_fifo_wr_t fifo;
    logic sync_accept;
    logic packet_done;
    logic [15:0] tx_crc;
    logic tx_crc_append;
    logic [8:0] tx_pn9;
    logic tx_bit_out;
    logic rx_serial_out;
  } rph_state_t;
endpackage

/* File: rph_packet_handler.sv */
// Purpose: Packet handling for a radio transceiver: preamble quality, sync gate,
//   address filter, dewhitening, CRC, status append and data path selection.
// Assumes: Demodulator signals are on clk; received bytes are at least two
//   cycles apart; serial port pins and the transmit data pin are asynchronous.
// Notes: Serial port is mode 0; header bit 7 reads, bit 6 bursts.
`timescale 1ns/1ps
module rph_packet_handler #(
  parameter logic [15:0] LEGACY_CRC_POLY = rph_pkg::CRC_POLY_LEGACY
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_csn_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire rph_pkg::rph_rx_in_t rx_in,
  input wire logic [7:0] rssi_value,
  input wire logic [6:0] link_quality_value,
  output rph_pkg::rph_fifo_wr_t rx_fifo,
  output logic sync_accept,
  output logic packet_done,
  output logic crc_ok,
  input wire logic tx_start,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic [15:0] tx_crc,
  output logic tx_crc_append,
  input wire logic tx_bit_req,
  input wire logic tx_fifo_bit,
  input wire logic general_output_pin_zero,
  output logic tx_bit_out,
  output logic rx_serial_out
);
  if (LEGACY_CRC_POLY[0] == 1'b0) begin : g_bad_poly
    $error("legacy CRC polynomial must have its constant term set");
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                           input logic [15:0] poly);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    end
    return r;
  endfunction

  function automatic logic [8:0] pn9_step(input logic [8:0] s);
    return {s[0] ^ s[5], s[8:1]};
  endfunction

  rph_pkg::rph_state_t st_ff;
  rph_pkg::rph_state_t nxt_st;

  // Configuration fields.
  logic [2:0] preamble_quality_threshold;
  logic autoflush;
  logic append;
  logic [1:0] adr_mode;
  logic white;
  logic [1:0] fmt;
  logic compat;
  logic crc_en;
  logic [1:0] len_mode;
  logic [15:0] poly;
  logic sync_ok;
  logic [7:0] rx_d;
  logic addr_match;
  assign preamble_quality_threshold = st_ff.ctrl_one[rph_pkg::PQT_LSB +: 3];
  assign autoflush = st_ff.ctrl_one[rph_pkg::AUTOFLUSH_BIT];
  assign append = st_ff.ctrl_one[rph_pkg::APPEND_BIT];
  assign adr_mode = st_ff.ctrl_one[rph_pkg::ADR_MODE_LSB +: 2];
  assign white = st_ff.ctrl_zero[rph_pkg::WHITE_BIT];
  assign fmt = st_ff.ctrl_zero[rph_pkg::FMT_LSB +: 2];
  assign compat = st_ff.ctrl_zero[rph_pkg::COMPAT_BIT];
  assign crc_en = st_ff.ctrl_zero[rph_pkg::CRC_EN_BIT];
  assign len_mode = st_ff.ctrl_zero[rph_pkg::LEN_MODE_LSB +: 2];
  // The legacy polynomial is a separate constant so both checks stay available.
  assign poly = compat ? LEGACY_CRC_POLY : rph_pkg::CRC_POLY;
  assign sync_ok = (preamble_quality_threshold == 3'h0) || (st_ff.pq >= (5'(preamble_quality_threshold) << rph_pkg::PQT_SHIFT));
  assign rx_d = white ? (rx_in.byte_data ^ st_ff.rx_pn9[7:0]) : rx_in.byte_data;
  assign addr_match = (rx_d == st_ff.node_addr) ||
    (adr_mode[1] && rx_d == rph_pkg::BCAST_LOW) ||
    (adr_mode == rph_pkg::ADR_BCAST_BOTH && rx_d == rph_pkg::BCAST_HIGH);

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] sh;
    logic [5:0] raddr;
    logic [7:0] rdata;
    logic load;
    logic go_tail;
    logic fin;
    logic ok_v;
    logic [15:0] c_v;
    sh = 8'h00;
    raddr = st_ff.spi_addr;
    rdata = 8'h00;
    load = 1'b0;
    go_tail = 1'b0;
    fin = 1'b0;
    ok_v = st_ff.crc_ok;
    c_v = crc_byte(st_ff.rx_crc, rx_d, poly);
    nxt_st = st_ff;
    nxt_st.sclk_s = {st_ff.sclk_s[1:0], spi_sclk};
    nxt_st.csn_s = {st_ff.csn_s[0], spi_csn_n};
    nxt_st.si_s = {st_ff.si_s[0], spi_si};
    nxt_st.gp0_s = {st_ff.gp0_s[0], general_output_pin_zero};
    nxt_st.fifo = '0;
    nxt_st.sync_accept = 1'b0;
    nxt_st.packet_done = 1'b0;

    // Serial register port. Sample on rising clock, shift out on falling.
    nxt_st.spi_so_oe = ~st_ff.csn_s[1];
    if (st_ff.csn_s[1]) begin
      nxt_st.spi_cnt = 4'h0;
    end else if (st_ff.sclk_s[1] && !st_ff.sclk_s[2]) begin
      sh = {st_ff.spi_rx_sh[6:0], st_ff.si_s[1]};
      nxt_st.spi_rx_sh = sh;
      if (st_ff.spi_cnt == rph_pkg::SPI_HDR_LAST) begin
        nxt_st.spi_rd = sh[rph_pkg::SPI_RD_BIT];
        nxt_st.spi_burst = sh[rph_pkg::SPI_BURST_BIT];
        nxt_st.spi_addr = sh[5:0];
        raddr = sh[5:0];
        load = 1'b1;
        nxt_st.spi_cnt = rph_pkg::SPI_DATA_FIRST;
      end else if (st_ff.spi_cnt == rph_pkg::SPI_DATA_LAST) begin
        if (!st_ff.spi_rd) begin
          case (st_ff.spi_addr)
            rph_pkg::REG_MAX_LEN: nxt_st.max_len = sh;
            rph_pkg::REG_PKT_CTRL_ONE: nxt_st.ctrl_one = sh & rph_pkg::MASK_PKT_CTRL_ONE;
            rph_pkg::REG_PKT_CTRL_ZERO: nxt_st.ctrl_zero = sh & rph_pkg::MASK_PKT_CTRL_ZERO;
            rph_pkg::REG_NODE_ADDR: nxt_st.node_addr = sh;
            default: ;
          endcase
        end
        if (st_ff.spi_burst) begin
          raddr = st_ff.spi_addr + 6'h01;
        end
        nxt_st.spi_addr = raddr;
        load = 1'b1;
        nxt_st.spi_cnt = rph_pkg::SPI_DATA_FIRST;
      end else begin
        nxt_st.spi_cnt = st_ff.spi_cnt + 4'h1;
      end
    end else if (!st_ff.sclk_s[1] && st_ff.sclk_s[2] &&
                 st_ff.spi_cnt > rph_pkg::SPI_DATA_FIRST) begin
      nxt_st.spi_tx_sh = {st_ff.spi_tx_sh[6:0], 1'b0};
      nxt_st.spi_so = st_ff.spi_tx_sh[6];
    end
    // Unmapped addresses read as zero; reserved bits are held at zero on write.
    case (raddr)
      rph_pkg::REG_MAX_LEN: rdata = st_ff.max_len;
      rph_pkg::REG_PKT_CTRL_ONE: rdata = st_ff.ctrl_one;
      rph_pkg::REG_PKT_CTRL_ZERO: rdata = st_ff.ctrl_zero;
      rph_pkg::REG_NODE_ADDR: rdata = st_ff.node_addr;
      default: rdata = 8'h00;
    endcase
    if (load) begin
      nxt_st.spi_tx_sh = rdata;
      nxt_st.spi_so = rdata[7];
    end

    // Preamble quality and transparent receive output.
    if (rx_in.bit_valid) begin
      nxt_st.prev_bit = rx_in.bit_val;
      if (rx_in.bit_val != st_ff.prev_bit) begin
        nxt_st.pq = (st_ff.pq == rph_pkg::PQ_MAX) ? st_ff.pq : st_ff.pq + rph_pkg::PQ_UP;
      end else begin
        nxt_st.pq = (st_ff.pq < rph_pkg::PQ_DOWN) ? 5'h00 : st_ff.pq - rph_pkg::PQ_DOWN;
      end
      nxt_st.rx_serial_out = fmt[0] & rx_in.bit_val;
    end

    // Receive packet engine. A pending address byte is written one cycle late.
    if (st_ff.pend) begin
      nxt_st.fifo.valid = 1'b1;
      nxt_st.fifo.data = st_ff.pend_data;
      nxt_st.pend = 1'b0;
    end
    if (rx_in.end_frame && st_ff.rx_state != rph_pkg::RX_IDLE &&
        st_ff.rx_state != rph_pkg::RX_STAT_RSSI && st_ff.rx_state != rph_pkg::RX_STAT_LQI) begin
      if (len_mode == rph_pkg::LEN_INFINITE && st_ff.rx_state == rph_pkg::RX_DATA) begin
        nxt_st.packet_done = 1'b1;
      end
      nxt_st.rx_state = rph_pkg::RX_IDLE;
    end else begin
      case (st_ff.rx_state)
        rph_pkg::RX_IDLE: begin
          if (rx_in.sync_hit && sync_ok && !fmt[0]) begin
            nxt_st.sync_accept = 1'b1;
            nxt_st.rx_pn9 = rph_pkg::PN9_SEED;
            nxt_st.rx_crc = rph_pkg::CRC_INIT;
            nxt_st.crc_ok = 1'b0;
            nxt_st.rem = st_ff.max_len;
            if (len_mode == rph_pkg::LEN_VARIABLE) begin
              nxt_st.rx_state = rph_pkg::RX_LEN;
            end else if (adr_mode != rph_pkg::ADR_OFF) begin
              nxt_st.rx_state = rph_pkg::RX_ADDR;
            end else begin
              nxt_st.rx_state = rph_pkg::RX_DATA;
            end
          end
        end
        rph_pkg::RX_LEN: begin
          if (rx_in.byte_valid) begin
            nxt_st.rx_crc = c_v;
            nxt_st.rem = rx_d;
            nxt_st.len_hold = rx_d;
            if (rx_d > st_ff.max_len) begin
              nxt_st.rx_state = rph_pkg::RX_IDLE;
            end else if (adr_mode != rph_pkg::ADR_OFF && rx_d != 8'h00) begin
              nxt_st.rx_state = rph_pkg::RX_ADDR;
            end else begin
              nxt_st.fifo.valid = 1'b1;
              nxt_st.fifo.data = rx_d;
              nxt_st.rx_state = rph_pkg::RX_DATA;
              go_tail = (rx_d == 8'h00);
            end
          end
        end
        rph_pkg::RX_ADDR: begin
          if (rx_in.byte_valid) begin
            nxt_st.rx_crc = c_v;
            if (!addr_match) begin
              nxt_st.rx_state = rph_pkg::RX_IDLE;
            end else begin
              nxt_st.fifo.valid = 1'b1;
              nxt_st.rem = st_ff.rem - 8'h01;
              nxt_st.rx_state = rph_pkg::RX_DATA;
              go_tail = (st_ff.rem == 8'h01) && len_mode != rph_pkg::LEN_INFINITE;
              if (len_mode == rph_pkg::LEN_VARIABLE) begin
                nxt_st.fifo.data = st_ff.len_hold;
                nxt_st.pend = 1'b1;
                nxt_st.pend_data = rx_d;
              end else begin
                nxt_st.fifo.data = rx_d;
              end
            end
          end
        end
        rph_pkg::RX_DATA: begin
          if (rx_in.byte_valid) begin
            nxt_st.rx_crc = c_v;
            nxt_st.fifo.valid = 1'b1;
            nxt_st.fifo.data = rx_d;
            nxt_st.rem = st_ff.rem - 8'h01;
            go_tail = (st_ff.rem == 8'h01) && len_mode != rph_pkg::LEN_INFINITE;
          end
        end
        rph_pkg::RX_CRC_HI: begin
          if (rx_in.byte_valid) begin
            nxt_st.rx_crc = c_v;
            nxt_st.rx_state = rph_pkg::RX_CRC_LO;
          end
        end
        rph_pkg::RX_CRC_LO: begin
          if (rx_in.byte_valid) begin
            // A clean packet leaves a zero remainder after its own check bytes.
            ok_v = (c_v == 16'h0000);
            nxt_st.crc_ok = ok_v;
            if (append) begin
              nxt_st.rx_state = rph_pkg::RX_STAT_RSSI;
            end else begin
              fin = 1'b1;
            end
          end
        end
        rph_pkg::RX_STAT_RSSI: begin
          // A late address byte owns the write port this cycle, so the status waits.
          if (!st_ff.pend) begin
            nxt_st.fifo.valid = 1'b1;
            nxt_st.fifo.data = rssi_value;
            nxt_st.rx_state = rph_pkg::RX_STAT_LQI;
          end
        end
        rph_pkg::RX_STAT_LQI: begin
          nxt_st.fifo.valid = 1'b1;
          nxt_st.fifo.data = {st_ff.crc_ok, link_quality_value};
          fin = 1'b1;
        end
        default: nxt_st.rx_state = rph_pkg::RX_IDLE;
      endcase
      if (rx_in.byte_valid && st_ff.rx_state != rph_pkg::RX_IDLE) begin
        nxt_st.rx_pn9 = pn9_step(pn9_step(pn9_step(pn9_step(
          pn9_step(pn9_step(pn9_step(pn9_step(st_ff.rx_pn9))))))));
      end
      if (go_tail) begin
        if (crc_en) begin
          nxt_st.rx_state = rph_pkg::RX_CRC_HI;
        end else if (append) begin
          nxt_st.rx_state = rph_pkg::RX_STAT_RSSI;
        end else begin
          fin = 1'b1;
        end
      end
      if (fin) begin
        nxt_st.packet_done = 1'b1;
        nxt_st.fifo.flush = autoflush & crc_en & ~ok_v;
        nxt_st.rx_state = rph_pkg::RX_IDLE;
      end
    end

    // Transmit side: check word and bit source.
    nxt_st.tx_crc_append = crc_en;
    if (tx_start) begin
      nxt_st.tx_crc = rph_pkg::CRC_INIT;
    end else if (tx_byte_valid && crc_en) begin
      nxt_st.tx_crc = crc_byte(st_ff.tx_crc, tx_byte, poly);
    end
    if (tx_bit_req) begin
      case (fmt)
        rph_pkg::FMT_FIFO: nxt_st.tx_bit_out = tx_fifo_bit;
        rph_pkg::FMT_PN9: begin
          nxt_st.tx_bit_out = st_ff.tx_pn9[0];
          nxt_st.tx_pn9 = pn9_step(st_ff.tx_pn9);
        end
        default: nxt_st.tx_bit_out = st_ff.gp0_s[1];
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.max_len <= rph_pkg::RST_MAX_LEN;
      st_ff.ctrl_one <= rph_pkg::RST_PKT_CTRL_ONE;
      st_ff.ctrl_zero <= rph_pkg::RST_PKT_CTRL_ZERO;
      st_ff.node_addr <= rph_pkg::RST_NODE_ADDR;
      st_ff.sclk_s <= 3'h0;
      st_ff.csn_s <= 2'h3;
      st_ff.rx_pn9 <= rph_pkg::PN9_SEED;
      st_ff.tx_pn9 <= rph_pkg::PN9_SEED;
      st_ff.rx_crc <= rph_pkg::CRC_INIT;
      st_ff.tx_crc <= rph_pkg::CRC_INIT;
      st_ff.rx_state <= rph_pkg::RX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign spi_so = st_ff.spi_so;
  assign spi_so_oe = st_ff.spi_so_oe;
  assign rx_fifo = st_ff.fifo;
  assign sync_accept = st_ff.sync_accept;
  assign packet_done = st_ff.packet_done;
  assign crc_ok = st_ff.crc_ok;
  assign tx_crc = st_ff.tx_crc;
  assign tx_crc_append = st_ff.tx_crc_append;
  assign tx_bit_out = st_ff.tx_bit_out;
  assign rx_serial_out = st_ff.rx_serial_out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_bit_change;
    rx_in.bit_valid && rx_in.bit_val != st_ff.prev_bit;
  endsequence
  sequence s_bit_same;
    rx_in.bit_valid && rx_in.bit_val == st_ff.prev_bit;
  endsequence
  logic [15:0] c_v_chk;
  assign c_v_chk = crc_byte(st_ff.rx_crc, rx_d, poly);
  sequence s_bad_end;
    st_ff.rx_state == rph_pkg::RX_CRC_LO && rx_in.byte_valid && !rx_in.end_frame &&
      crc_en && autoflush && !append && c_v_chk != 16'h0000;
  endsequence

  chk_pq_rise: assert property (s_bit_change ##0 (st_ff.pq < rph_pkg::PQ_MAX)
    |=> st_ff.pq == $past(st_ff.pq) + 5'h01) else $error("quality did not rise");
  chk_pq_fall: assert property (s_bit_same ##0 (st_ff.pq >= rph_pkg::PQ_DOWN)
    |=> st_ff.pq == $past(st_ff.pq) - 5'h04) else $error("quality did not fall");
  chk_pq_floor: assert property (s_bit_same ##0 (st_ff.pq < rph_pkg::PQ_DOWN)
    |=> st_ff.pq == 5'h00) else $error("quality floor missed");
  chk_sync_gate: assert property (sync_accept |-> $past(rx_in.sync_hit) &&
    ($past(preamble_quality_threshold) == 3'h0 || $past(st_ff.pq) >= ($past(5'(preamble_quality_threshold)) << 2)))
    else $error("sync accepted below threshold");
  chk_bad_flush: assert property (s_bad_end |=> rx_fifo.flush && packet_done)
    else $error("bad packet not flushed");
  chk_status_pair: assert property (st_ff.rx_state == rph_pkg::RX_STAT_RSSI && !st_ff.pend
    |=> rx_fifo.valid && rx_fifo.data == $past(rssi_value) ##1 rx_fifo.valid && packet_done)
    else $error("status bytes missing");
  chk_addr_drop: assert property (st_ff.rx_state == rph_pkg::RX_ADDR && rx_in.byte_valid &&
    !rx_in.end_frame && !addr_match |=> st_ff.rx_state == rph_pkg::RX_IDLE && !rx_fifo.valid)
    else $error("foreign packet kept");
  chk_bcast_high: assert property (st_ff.rx_state == rph_pkg::RX_ADDR && rx_in.byte_valid &&
    !rx_in.end_frame && adr_mode == rph_pkg::ADR_BCAST_BOTH && rx_d == rph_pkg::BCAST_HIGH
    |=> rx_fifo.valid) else $error("broadcast refused");
  chk_len_limit: assert property (st_ff.rx_state == rph_pkg::RX_LEN && rx_in.byte_valid &&
    !rx_in.end_frame && rx_d > st_ff.max_len |=> st_ff.rx_state == rph_pkg::RX_IDLE && !rx_fifo.valid)
    else $error("overlong packet kept");
  chk_tx_pn9: assert property (tx_bit_req && fmt == rph_pkg::FMT_PN9
    |=> tx_bit_out == $past(st_ff.tx_pn9[0])) else $error("random bit wrong");
  chk_flush_bad: assert property (rx_fifo.flush |-> !crc_ok && packet_done)
    else $error("good packet flushed");
endmodule

/* File: rph_remote_radio.sv */
// Purpose: Remote radio model feeding demodulated bits, sync hits and bytes.
// Assumes: One packet in flight at a time, never longer than the FIFO.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
module rph_remote_radio (
  input wire logic clk,
  output rph_pkg::rph_rx_in_t rx_in
);
  initial rx_in = '0;
  task automatic emit(input logic b, input int n, input logic alt);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rx_in.bit_valid <= 1'b1;
      rx_in.bit_val <= b;
      @(posedge clk) rx_in.bit_valid <= 1'b0;
      rx_in.bit_val <= ~b;
      if (alt) b = ~b;
    end
  endtask
  task automatic mark(input logic stop);
    @(posedge clk) rx_in.sync_hit <= !stop;
    rx_in.end_frame <= stop;
    @(posedge clk) rx_in.sync_hit <= 1'b0;
    rx_in.end_frame <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d [$]);
    mark(1'b0);
    foreach (d[i]) begin
      @(posedge clk) rx_in.byte_valid <= 1'b1;
      rx_in.byte_data <= d[i];
      @(posedge clk) rx_in.byte_valid <= 1'b0;
      rx_in.byte_data <= ~d[i];
      @(posedge clk);
    end
  endtask
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the packet handler.
// Assumes: Serial port clock high for six clocks and low for seven.
// Notes: Status bytes use fixed signal strength 0xA7 and link quality 0x35.
`timescale 1ns/1ps
module testbench;
  logic clk, rst, sclk, csn_n, si, pin0, fifo_bit, bit_req;
  logic so, so_oe, s_acc, p_done, c_ok, tx_out, ser_out;
  logic tx_go, tx_bv, oe_rd, crc_ap;
  logic [7:0] tx_b;
  logic [15:0] crc_w;
  rph_pkg::rph_rx_in_t rx_in;
  rph_pkg::rph_fifo_wr_t wr;
  logic [7:0] q [$];
  logic [7:0] rd;
  int n_errors = 0, n_checks = 0, n_sync = 0, n_done = 0, n_flush = 0;
  rph_packet_handler dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_csn_n(csn_n),
    .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .rx_in(rx_in), .rssi_value(8'hA7),
    .link_quality_value(7'h35), .rx_fifo(wr), .sync_accept(s_acc), .packet_done(p_done),
    .crc_ok(c_ok), .tx_start(tx_go), .tx_byte_valid(tx_bv), .tx_byte(tx_b), .tx_crc(crc_w),
    .tx_crc_append(crc_ap), .tx_bit_req(bit_req), .tx_fifo_bit(fifo_bit),
    .general_output_pin_zero(pin0), .tx_bit_out(tx_out), .rx_serial_out(ser_out));
  rph_remote_radio remote (.clk(clk), .rx_in(rx_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr.valid === 1'b1) q.push_back(wr.data);
    if (s_acc === 1'b1) n_sync++;
    if (p_done === 1'b1) n_done++;
    if (wr.flush === 1'b1) n_flush++;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic spi(input logic [7:0] hdr, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {hdr, wd};
    @(posedge clk) csn_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) si <= sh[i];
      repeat (6) @(posedge clk);
      if (i < 8) rd[i] = so;
      if (i == 0) oe_rd = so_oe;
      sclk <= 1'b1;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    csn_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    spi(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    spi(8'h80 | a, 8'h00);
    chk_byte(rd, e);
    chk_byte({7'h0, oe_rd}, 8'h01);
    chk_byte({7'h0, so_oe}, 8'h00);
  endtask
  task automatic try_sync(input int e);
    int s;
    s = n_sync;
    remote.mark(1'b0);
    repeat (4) @(posedge clk);
    chk_num(n_sync - s, e);
    remote.mark(1'b1);
  endtask
  task automatic rx_pkt(input logic [7:0] d [$], input int e);
    int s;
    s = n_done;
    q.delete();
    remote.send(d);
    for (int i = 0; i < 40 && n_done == s; i++) @(posedge clk);
    chk_num(n_done - s, e);
  endtask
  task automatic t_regs();
    rd_chk(8'h07, 8'h04);
    rd_chk(8'h08, 8'h45);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h0A, 8'h00);
    wr_reg(8'h08, 8'hBF);
    rd_chk(8'h08, 8'h3F);
    wr_reg(8'h09, 8'h5A);
    rd_chk(8'h09, 8'h5A);
  endtask
  task automatic t_sync();
    wr_reg(8'h08, 8'h01);
    wr_reg(8'h07, 8'h40);
    remote.emit(1'b0, 9, 1'b0);
    remote.emit(1'b1, 7, 1'b1);
    try_sync(0);
    remote.emit(1'b0, 1, 1'b0);
    try_sync(1);
    remote.emit(1'b0, 9, 1'b0);
    remote.emit(1'b1, 40, 1'b1);
    remote.emit(1'b0, 7, 1'b0);
    try_sync(0);
    wr_reg(8'h07, 8'h00);
    try_sync(1);
  endtask
  task automatic t_addr();
    logic [7:0] a [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    int e;
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h07, m[7:0]);
      for (int j = 0; j < 4; j++) begin
        e = (m == 0 || j == 0 || (m >= 2 && j == 1) || (m == 3 && j == 2)) ? 1 : 0;
        rx_pkt({8'h02, a[j], 8'hC3}, e);
        chk_num(q.size(), 3 * e);
      end
    end
    wr_reg(8'h06, 8'h02);
    rx_pkt({8'h03, 8'h5A, 8'h01, 8'h02}, 0);
    chk_num(q.size(), 0);
  endtask
  task automatic t_status();
    int f;
    wr_reg(8'h06, 8'hFF);
    wr_reg(8'h07, 8'h0C);
    wr_reg(8'h08, 8'h05);
    f = n_flush;
    rx_pkt({8'h01, 8'h11, 8'h00, 8'h00}, 1);
    chk_num(n_flush - f, 1);
    chk_num(q.size(), 4);
    chk_byte(q[2], 8'hA7);
    chk_byte(q[3], 8'h35);
    chk_byte({7'h0, c_ok}, 8'h00);
    wr_reg(8'h07, 8'h08);
    f = n_flush;
    rx_pkt({8'h01, 8'h11, 8'h00, 8'h00}, 1);
    chk_num(n_flush - f, 1);
    chk_num(q.size(), 2);
  endtask
  task automatic tx_send(input logic [7:0] d);
    @(posedge clk) tx_bv <= 1'b1;
    tx_b <= d;
    @(posedge clk) tx_bv <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic t_crc();
    logic [15:0] c;
    int f;
    wr_reg(8'h08, 8'h05);
    wr_reg(8'h07, 8'h0C);
    chk_byte({7'h0, crc_ap}, 8'h01);
    tx_send(8'h01);
    tx_send(8'h11);
    c = crc_w;
    tx_send(c[15:8]);
    tx_send(c[7:0]);
    chk_byte(crc_w[15:8], 8'h00);
    chk_byte(crc_w[7:0], 8'h00);
    @(posedge clk) tx_go <= 1'b1;
    @(posedge clk) tx_go <= 1'b0;
    @(posedge clk) #1;
    chk_byte(crc_w[15:8], rph_pkg::CRC_INIT[15:8]);
    chk_byte(crc_w[7:0], rph_pkg::CRC_INIT[7:0]);
    f = n_flush;
    rx_pkt({8'h01, 8'h11, c[15:8], c[7:0]}, 1);
    chk_num(n_flush - f, 0);
    chk_byte(q[3], 8'hB5);
    chk_byte({7'h0, c_ok}, 8'h01);
  endtask
  task automatic t_len();
    int s;
    wr_reg(8'h07, 8'h00);
    wr_reg(8'h06, 8'h01);
    wr_reg(8'h08, 8'h40);
    rx_pkt({8'hEE}, 1);
    chk_num(q.size(), 1);
    chk_byte(q[0], 8'hEE ^ rph_pkg::PN9_SEED[7:0]);
    wr_reg(8'h08, 8'h02);
    s = n_done;
    q.delete();
    remote.send({8'h11, 8'h22, 8'h33});
    remote.mark(1'b1);
    repeat (3) @(posedge clk);
    chk_num(n_done - s, 1);
    chk_num(q.size(), 3);
  endtask
  task automatic tx_bit();
    @(posedge clk) bit_req <= 1'b1;
    @(posedge clk) bit_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_tx();
    logic [1:0] f [3] = '{2'h0, 2'h1, 2'h3};
    for (int k = 0; k < 6; k++) begin
      wr_reg(8'h08, {2'b00, f[k / 2], 4'h1});
      @(posedge clk) pin0 <= k[0] ^ (f[k / 2] == 2'h0);
      fifo_bit <= k[0] ^ (f[k / 2] != 2'h0);
      repeat (3) @(posedge clk);
      tx_bit();
      chk_byte({7'h0, tx_out}, {7'h0, k[0]});
      remote.emit(k[0], 1, 1'b0);
      #1;
      chk_byte({7'h0, ser_out}, {7'h0, k[0] & f[k / 2][0]});
    end
    wr_reg(8'h08, 8'h01);
    @(posedge clk) fifo_bit <= 1'b0;
    pin0 <= 1'b0;
    tx_bit();
    chk_byte({7'h0, tx_out}, 8'h00);
    wr_reg(8'h08, 8'h21);
    tx_bit();
    chk_byte({7'h0, tx_out}, {7'h0, rph_pkg::PN9_SEED[0]});
    chk_byte({7'h0, crc_ap}, 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    sclk = 1'b0;
    csn_n = 1'b1;
    si = 1'b0;
    pin0 = 1'b0;
    fifo_bit = 1'b0;
    bit_req = 1'b0;
    tx_go = 1'b0;
    tx_bv = 1'b0;
    tx_b = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_sync();
    t_addr();
    t_status();
    t_crc();
    t_len();
    t_tx();
    give_verdict();
  end
endmodule
